// *** rtl/pfcm_params.svh ***
// Purpose: constants of the parallel flash configuration master
// Assumes: 100 MHz system clock
// Notes: counts derive from the times beside them
`ifndef PFCM_PARAMS_SVH
`define PFCM_PARAMS_SVH
`define PFCM_CLK_PERIOD_NS 10
`define PFCM_CCLK_MAX_PERIOD_NS 50
// longest period rounds down, half of it per phase
`define PFCM_CCLK_HALF_CYCLES ((`PFCM_CCLK_MAX_PERIOD_NS / `PFCM_CLK_PERIOD_NS) / 2)
`define PFCM_RESTART_MIN_NS 500
`define PFCM_RESTART_MIN_CYCLES \
  ((`PFCM_RESTART_MIN_NS + `PFCM_CLK_PERIOD_NS - 1) / `PFCM_CLK_PERIOD_NS)
`define PFCM_BOOT_WORD_ADDR 24'h010000
`define PFCM_BOOT_BYTE_ADDR 25'h0020000
`define PFCM_CONFIG_WORDS 600000
`define PFCM_SYNC_W 20
`define PFCM_SYNC_RESTART 16
`define PFCM_SYNC_CE 17
`define PFCM_SYNC_PSCLK 18
`define PFCM_SYNC_PSDATA 19
`endif

// *** rtl/pfcm_pkg.sv ***
// Purpose: types of the parallel flash configuration master
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package pfcm_pkg;
  typedef enum logic [3:0] {
    PFCM_OFF = 4'h1,
    PFCM_READ = 4'h2,
    PFCM_DONE = 4'h4,
    PFCM_ISP = 4'h8
  } pfcm_state_e;
  typedef enum logic [1:0] {
    PFCM_ACTIVE_PARALLEL = 2'h0,
    PFCM_ACTIVE_SERIAL = 2'h1,
    PFCM_PASSIVE_SERIAL = 2'h2
  } pfcm_scheme_e;
  typedef struct packed {
    logic [23:0] addr;
    logic ceN;
    logic oeN;
    logic weN;
    logic avdN;
  } pfcm_flash_s;
  typedef struct packed {
    logic strobe;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pfcm_isp_s;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pfcm_word_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pfcm_byte_s;
endpackage
`default_nettype wire

// *** rtl/pfcm_config_master.sv ***
// Purpose: active parallel flash configuration master with bus handover
// Assumes: 100 MHz clk; flash and serial pins asynchronous to clk
// Notes: flash wait line deliberately has no port
// Functional notes
// [R1] other master holds restart low 500 ns
// [R2] restart low tri-states all flash bus outputs
// [R3] other master releases bus, enable, then pulses restart
// [R4] drive flash bus only while enable grants
// [R5] other master claims bus by driving enable high
// [R6] flash wait ignored while configuring
// [R7] config clock from internal divider, period 50 ns max
// [R8] one 16-bit word per config clock cycle
// [R9] default boot word address 0x010000
// [R10] test-port instruction replaces boot address
// [R11] test port programs flash in system
// [R12] passive serial: one bit per rising clock
// [R13] restart release re-reads from current boot address; with ispEnable high the code goes to test-port mode and skips the read
`include "pfcm_params.svh"
`default_nettype none
module pfcm_config_master #(
  parameter int CONFIG_WORDS = `PFCM_CONFIG_WORDS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic configRestartN,
  input wire logic chipEnableN,
  input wire logic [1:0] schemeSel,
  input wire logic [15:0] flashDataIn,
  input wire logic psClock,
  input wire logic psData,
  input wire logic bootAddrLoad,
  input wire logic [23:0] bootAddrValue,
  input wire logic ispEnable,
  input wire pfcm_pkg::pfcm_isp_s ispCmd,
  output pfcm_pkg::pfcm_flash_s flashBus,
  output logic flashBusOeN,
  output logic [15:0] flashDataOut,
  output logic flashDataOeN,
  output logic configClock,
  output pfcm_pkg::pfcm_word_s cfgWord,
  output logic [15:0] ispReadData,
  output pfcm_pkg::pfcm_byte_s psByte,
  output logic configDone
);
  if (CONFIG_WORDS < 1 || CONFIG_WORDS > 24'hFFFFFF) begin : g_chk
    $error("CONFIG_WORDS out of range");
  end
  localparam logic [2:0] HALF = 3'(`PFCM_CCLK_HALF_CYCLES);
  if (`PFCM_CCLK_HALF_CYCLES < 1) begin : g_chk_clk
    $error("config clock half period below one cycle");
  end

  ////////////////////////////////////////////////////////////////////////
  logic rstMeta, rstSync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // data, restart, enable and serial pins pass two flops; first stage read by second only
  logic [`PFCM_SYNC_W-1:0] syncA, syncB;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {psData, psClock, chipEnableN, configRestartN, flashDataIn};
      syncB <= syncA;
    end
  end
  logic restartHigh, grantLost, psClkS, psDataS;
  logic [15:0] dataS;
  assign restartHigh = syncB[`PFCM_SYNC_RESTART];
  assign grantLost = syncB[`PFCM_SYNC_CE];
  assign psClkS = syncB[`PFCM_SYNC_PSCLK];
  assign psDataS = syncB[`PFCM_SYNC_PSDATA];
  assign dataS = syncB[15:0];

  // strap caught once, after reset release
  pfcm_pkg::pfcm_scheme_e scheme;
  logic strapTaken;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      scheme <= pfcm_pkg::PFCM_ACTIVE_PARALLEL;
      strapTaken <= 1'b0;
    end else if (!strapTaken) begin
      scheme <= pfcm_pkg::pfcm_scheme_e'(schemeSel);
      strapTaken <= 1'b1;
    end
  end
  logic apMode;
  assign apMode = strapTaken && (scheme == pfcm_pkg::PFCM_ACTIVE_PARALLEL);

  ////////////////////////////////////////////////////////////////////////
  // boot address survives restart pulses; only rst_n restores it
  logic [23:0] bootAddr;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      bootAddr <= `PFCM_BOOT_WORD_ADDR; // [R9]
    end else if (bootAddrLoad) begin
      bootAddr <= bootAddrValue; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  pfcm_pkg::pfcm_state_e state, next_state;
  logic [2:0] divCnt;
  logic cclkRise, lastWord;
  logic [23:0] wordCnt;
  assign cclkRise = (state == pfcm_pkg::PFCM_READ) && (divCnt == HALF - 3'h1) && !configClock;
  assign lastWord = (wordCnt == 24'(CONFIG_WORDS - 1));

  always_comb begin
    next_state = state;
    if (!restartHigh || grantLost || !apMode) begin
      next_state = pfcm_pkg::PFCM_OFF; // [R2] [R4]
    end else begin
      unique case (state)
        pfcm_pkg::PFCM_OFF: begin
          next_state = ispEnable ? pfcm_pkg::PFCM_ISP : pfcm_pkg::PFCM_READ; // [R13]
        end
        pfcm_pkg::PFCM_READ: begin
          if (cclkRise && lastWord) begin
            next_state = pfcm_pkg::PFCM_DONE;
          end
        end
        pfcm_pkg::PFCM_DONE: begin
          if (ispEnable) begin
            next_state = pfcm_pkg::PFCM_ISP;
          end
        end
        pfcm_pkg::PFCM_ISP: begin
          if (!ispEnable) begin
            next_state = pfcm_pkg::PFCM_DONE;
          end
        end
        default: next_state = pfcm_pkg::PFCM_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= pfcm_pkg::PFCM_OFF;
    end else begin
      state <= next_state;
    end
  end

  // enable tracks the next state so release lands on the same edge
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      flashBusOeN <= 1'b1;
      configDone <= 1'b0;
    end else begin
      flashBusOeN <= !(next_state inside {pfcm_pkg::PFCM_READ, pfcm_pkg::PFCM_ISP}); // [R2] [R4]
      configDone <= (next_state == pfcm_pkg::PFCM_DONE) ||
                    (configDone && next_state == pfcm_pkg::PFCM_ISP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // free divider; wait from flash never stalls it
  // idle count one below zero: first rise lands 3 cycles after the address,
  // once the two-flop data sync has caught the first word
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      divCnt <= 3'h7;
      configClock <= 1'b0;
    end else if (state != pfcm_pkg::PFCM_READ) begin
      divCnt <= 3'h7;
      configClock <= 1'b0;
    end else if (divCnt == HALF - 3'h1) begin
      divCnt <= 3'h0;
      configClock <= !configClock; // [R7] [R6]
    end else begin
      divCnt <= divCnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      flashBus <= '{addr: `PFCM_BOOT_WORD_ADDR, ceN: 1'b1, oeN: 1'b1, weN: 1'b1, avdN: 1'b1};
      flashDataOut <= 16'h0000;
      flashDataOeN <= 1'b1;
      wordCnt <= 24'h000000;
      cfgWord <= '0;
      ispReadData <= 16'h0000;
    end else begin
      cfgWord.valid <= 1'b0;
      // last word is taken on the edge that leaves for done
      if (cclkRise && next_state != pfcm_pkg::PFCM_OFF) begin
        cfgWord <= '{valid: 1'b1, data: dataS}; // [R8]
        flashBus.addr <= flashBus.addr + 24'h000001;
        wordCnt <= wordCnt + 24'h000001;
      end
      unique case (next_state)
        pfcm_pkg::PFCM_READ: begin
          flashDataOeN <= 1'b1;
          flashBus.ceN <= 1'b0;
          flashBus.oeN <= 1'b0;
          flashBus.weN <= 1'b1;
          flashBus.avdN <= 1'b0;
          if (state != pfcm_pkg::PFCM_READ) begin
            flashBus.addr <= bootAddr; // [R13] [R9]
            wordCnt <= 24'h000000;
          end
        end
        pfcm_pkg::PFCM_ISP: begin
          flashBus.ceN <= 1'b0;
          flashBus.avdN <= 1'b0;
          ispReadData <= dataS;
          if (ispCmd.strobe) begin
            flashBus.addr <= ispCmd.addr; // [R11]
            flashBus.oeN <= ispCmd.write;
            flashBus.weN <= !ispCmd.write;
            flashDataOut <= ispCmd.wdata;
            flashDataOeN <= !ispCmd.write;
          end else begin
            flashBus.weN <= 1'b1;
          end
        end
        default: begin
          flashBus.ceN <= 1'b1;
          flashBus.oeN <= 1'b1;
          flashBus.weN <= 1'b1;
          flashBus.avdN <= 1'b1;
          flashDataOeN <= 1'b1; // [R2]
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial bits come lsb first, so shift in from the top
  logic psClkPrev, psRise;
  logic [7:0] psShift;
  logic [2:0] psBitCnt;
  assign psRise = psClkS && !psClkPrev && strapTaken &&
                  (scheme == pfcm_pkg::PFCM_PASSIVE_SERIAL) && restartHigh;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      psClkPrev <= 1'b0;
      psShift <= 8'h00;
      psBitCnt <= 3'h0;
      psByte <= '0;
    end else begin
      psClkPrev <= psClkS;
      psByte.valid <= 1'b0;
      if (!restartHigh) begin
        psBitCnt <= 3'h0;
      end else if (psRise) begin
        psShift <= {psDataS, psShift[7:1]}; // [R12]
        psBitCnt <= psBitCnt + 3'h1;
        if (psBitCnt == 3'h7) begin
          psByte <= '{valid: 1'b1, data: {psDataS, psShift[7:1]}};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] highCnt;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      highCnt <= 3'h0;
    end else begin
      highCnt <= configClock ? highCnt + 3'h1 : 3'h0;
    end
  end

  property p_restart_release;
    @(posedge clk) disable iff (!rstSync) !restartHigh |=> flashBusOeN && flashDataOeN;
  endproperty
  a_restart_release: assert property (p_restart_release) // [R2]
    else $error("bus driven while restart low");
  property p_grant;
    @(posedge clk) disable iff (!rstSync) grantLost |=> flashBusOeN && flashBus.ceN;
  endproperty
  a_grant: assert property (p_grant) // [R4]
    else $error("bus driven without grant");
  property p_clk_high;
    @(posedge clk) disable iff (!rstSync) highCnt <= HALF;
  endproperty
  a_clk_high: assert property (p_clk_high) // [R7]
    else $error("config clock phase too long");
  property p_clk_period;
    @(posedge clk) disable iff (!rstSync)
      $rose(configClock) && state == pfcm_pkg::PFCM_READ && next_state == state
      |=> configClock ##1 !configClock;
  endproperty
  a_clk_period: assert property (p_clk_period) // [R7]
    else $error("config clock period wrong");
  property p_word_on_rise;
    @(posedge clk) disable iff (!rstSync) cfgWord.valid |-> $rose(configClock);
  endproperty
  a_word_on_rise: assert property (p_word_on_rise) // [R8] [R6]
    else $error("word outside config clock rise");
  property p_boot_start;
    @(posedge clk) disable iff (!rstSync)
      state == pfcm_pkg::PFCM_OFF && next_state == pfcm_pkg::PFCM_READ
      |=> flashBus.addr == $past(bootAddr) && !flashBusOeN;
  endproperty
  a_boot_start: assert property (p_boot_start) // [R13] [R9]
    else $error("read did not start at boot address");
  property p_boot_load;
    @(posedge clk) disable iff (!rstSync) bootAddrLoad |=> bootAddr == $past(bootAddrValue);
  endproperty
  a_boot_load: assert property (p_boot_load) // [R10]
    else $error("boot address not replaced");
  property p_isp;
    @(posedge clk) disable iff (!rstSync)
      state == pfcm_pkg::PFCM_ISP && next_state == pfcm_pkg::PFCM_ISP && ispCmd.strobe
      |=> flashBus.addr == $past(ispCmd.addr) && flashBus.weN == !$past(ispCmd.write);
  endproperty
  a_isp: assert property (p_isp) // [R11]
    else $error("test port access not passed to flash");
  property p_ps_bit;
    @(posedge clk) disable iff (!rstSync) psRise |=> psShift[7] == $past(psDataS);
  endproperty
  a_ps_bit: assert property (p_ps_bit) // [R12]
    else $error("serial bit not captured");
  c_read_word: cover property (@(posedge clk) disable iff (!rstSync) cfgWord.valid);
  c_handover: cover property (@(posedge clk) disable iff (!rstSync)
    state == pfcm_pkg::PFCM_READ ##1 state == pfcm_pkg::PFCM_OFF);
  c_isp: cover property (@(posedge clk) disable iff (!rstSync) state == pfcm_pkg::PFCM_ISP);
  c_ps_byte: cover property (@(posedge clk) disable iff (!rstSync) psByte.valid);
endmodule
`default_nettype wire

// *** verif/pfcm_flash_model.sv ***
// Purpose: parallel flash seen from the configuration master's pins
// Assumes: asynchronous array read, one stored word from the test port
// Notes: floating data bus shows a pattern that moves every clock
`default_nettype none
module pfcm_flash_model (
  input wire logic clk,
  input wire pfcm_pkg::pfcm_flash_s flashBus,
  input wire logic flashBusOeN,
  input wire logic [15:0] flashDataOut,
  input wire logic flashDataOeN,
  output logic [15:0] flashData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] noise = 16'h1234;
  logic [23:0] wrAddr;
  logic [15:0] wrData;
  logic selected;
  ////////////////////////////////////////////////////////////////////////////
  assign selected = !flashBusOeN && !flashBus.ceN;
  // released bus never keeps its last value
  always @(posedge clk) noise <= noise + 16'h3B71;
  always @(posedge clk) begin
    if (selected && !flashBus.weN && !flashDataOeN) begin
      wrAddr <= flashBus.addr;
      wrData <= flashDataOut;
    end
  end
  // no wait line toward the master: reads never stall
  always_comb begin
    if (!flashDataOeN) begin
      flashData = flashDataOut;
    end else if (!selected || flashBus.oeN) begin
      flashData = noise;
    end else if (flashBus.addr === wrAddr) begin
      flashData = wrData;
    end else begin
      flashData = flashBus.addr[15:0] ^ 16'h5A3C;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: self-checking bench of the flash configuration master
// Assumes: word count shortened to 4, flash model on the far side
// Notes: bench plays the second bus master itself
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WORDS = 4;
  localparam logic [23:0] BOOT = 24'h010000;
  localparam logic [23:0] NEW_A = 24'h00ABC0;
  localparam logic [7:0] PS_BYTE = 8'h1B;
  logic clk, rst_n, configRestartN, chipEnableN, psClock, psData, bootAddrLoad, ispEnable;
  logic [1:0] schemeSel;
  logic [23:0] bootAddrValue;
  logic [15:0] flashData, flashDataOut, ispReadData;
  logic flashBusOeN, flashDataOeN, configClock, configDone;
  pfcm_pkg::pfcm_isp_s ispCmd;
  pfcm_pkg::pfcm_flash_s flashBus;
  pfcm_pkg::pfcm_word_s cfgWord;
  pfcm_pkg::pfcm_byte_s psByte;
  int bad_count = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  pfcm_config_master #(.CONFIG_WORDS(WORDS)) DUT (
    .clk(clk), .rst_n(rst_n), .configRestartN(configRestartN), .chipEnableN(chipEnableN),
    .schemeSel(schemeSel), .flashDataIn(flashData), .psClock(psClock), .psData(psData),
    .bootAddrLoad(bootAddrLoad), .bootAddrValue(bootAddrValue), .ispEnable(ispEnable),
    .ispCmd(ispCmd), .flashBus(flashBus), .flashBusOeN(flashBusOeN),
    .flashDataOut(flashDataOut), .flashDataOeN(flashDataOeN), .configClock(configClock),
    .cfgWord(cfgWord), .ispReadData(ispReadData), .psByte(psByte), .configDone(configDone));
  pfcm_flash_model FLASH (.clk(clk), .flashBus(flashBus), .flashBusOeN(flashBusOeN),
    .flashDataOut(flashDataOut), .flashDataOeN(flashDataOeN), .flashData(flashData));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic waited(string what, int n, int lim);
    if (n >= lim) begin
      bad_count++;
      $display("BAD %s expected in %0d cycles seen timeout", what, lim);
      report_and_stop();
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(logic [1:0] scheme);
    rst_n = 1'b0;
    schemeSel = scheme;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
  endtask
  // other master holds restart the full 500 ns
  task automatic pulse_restart();
    @(negedge clk) configRestartN = 1'b0;
    repeat (50) @(negedge clk);
    configRestartN = 1'b1;
  endtask
  task automatic start_read(logic [23:0] a);
    int n;
    for (n = 0; n < 20 && flashBusOeN !== 1'b0; n++) tick();
    waited("bus grant", n, 20);
    chk("start addr", a, flashBus.addr);
  endtask
  task automatic read_words(logic [23:0] a, int first, int cnt);
    int gap;
    logic [23:0] ak;
    for (int k = first; k < first + cnt; k++) begin
      gap = 0;
      ak = a + 24'(k);
      do begin
        tick();
        gap++;
      end while (cfgWord.valid !== 1'b1 && gap < 20);
      waited("config word", gap, 20);
      chkb("word within 50 ns", 1'b1, gap <= 5);
      chkb("clock rise at word", 1'b1, configClock);
      chk("word data", 24'(ak[15:0] ^ 16'h5A3C), 24'(cfgWord.data));
    end
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 20 && configDone !== 1'b1; n++) tick();
    waited("config done", n, 20);
    tick();
    chkb("bus released", 1'b1, flashBusOeN);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    start_read(BOOT);
    read_words(BOOT, 0, WORDS);
    wait_done();
    $display("test boot finished");
  endtask
  task automatic t_isp();
    int n;
    @(negedge clk) ispEnable = 1'b1;
    repeat (3) @(negedge clk);
    ispCmd = '{strobe: 1'b1, write: 1'b1, addr: 24'h000100, wdata: 16'hC3E1};
    tick();
    chkb("write strobe", 1'b0, flashBus.weN);
    chkb("data driven", 1'b0, flashDataOeN);
    chk("write addr", 24'h000100, flashBus.addr);
    @(negedge clk) ispCmd.strobe = 1'b0;
    tick();
    chkb("write strobe ends", 1'b1, flashBus.weN);
    @(negedge clk) ispCmd = '{strobe: 1'b1, write: 1'b0, addr: 24'h000100, wdata: 16'h0000};
    @(negedge clk) ispCmd.strobe = 1'b0;
    for (n = 0; n < 8 && ispReadData !== 16'hC3E1; n++) tick();
    chk("read back", 24'h00C3E1, 24'(ispReadData));
    @(negedge clk) ispEnable = 1'b0;
    $display("test isp finished");
  endtask
  task automatic t_handover();
    int n;
    pulse_restart();
    start_read(BOOT);
    read_words(BOOT, 0, 2);
    @(negedge clk) chipEnableN = 1'b1;
    configRestartN = 1'b0;
    repeat (4) tick();
    chkb("bus off in restart", 1'b1, flashBusOeN);
    chkb("data off in restart", 1'b1, flashDataOeN);
    chkb("no word in restart", 1'b0, cfgWord.valid);
    repeat (46) @(negedge clk);
    configRestartN = 1'b1;
    for (n = 0; n < 20 && flashBusOeN === 1'b1; n++) tick();
    chkb("bus kept off", 1'b1, n == 20);
    @(negedge clk) chipEnableN = 1'b0;
    pulse_restart();
    start_read(BOOT);
    read_words(BOOT, 0, WORDS);
    wait_done();
    $display("test handover finished");
  endtask
  task automatic t_boot_addr();
    pulse_restart();
    start_read(BOOT);
    read_words(BOOT, 0, 1);
    @(negedge clk) bootAddrLoad = 1'b1;
    bootAddrValue = NEW_A;
    @(negedge clk) bootAddrLoad = 1'b0;
    read_words(BOOT, 1, WORDS - 1);
    wait_done();
    pulse_restart();
    start_read(NEW_A);
    read_words(NEW_A, 0, WORDS);
    wait_done();
    $display("test boot address finished");
  endtask
  task automatic t_passive();
    int seen;
    logic [7:0] got;
    seen = 0;
    got = 8'h00;
    do_reset(2'h2);
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) psData = PS_BYTE[i]; // lsb first
      @(negedge clk) psClock = 1'b1;
      repeat (5) begin
        tick();
        if (psByte.valid === 1'b1) begin
          seen++;
          got = psByte.data;
        end
      end
      @(negedge clk) psClock = 1'b0;
    end
    chkb("one serial byte", 1'b1, seen == 1);
    chk("serial byte", 24'h00001B, 24'(got));
    chkb("flash bus idle", 1'b1, flashBusOeN);
    $display("test passive serial finished");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {configRestartN, chipEnableN, psClock, psData, bootAddrLoad, ispEnable} = 6'h20;
    bootAddrValue = 24'h000000;
    ispCmd = '0;
    do_reset(2'h0);
    t_boot();
    t_isp();
    t_handover();
    t_boot_addr();
    t_passive();
    report_and_stop();
  end
endmodule
`default_nettype wire
